/* File: fesp_pkg.sv */
// package: constants and types of the flash erase, protect and status controller
package fesp_pkg;
  localparam int SECT_LSB   = 12;  // 4KB sectors
  localparam int SECT_W     = 5;
  localparam int NSECT      = 32;
  localparam int INFO_NSECT = 2;
  localparam int ADDR_W     = 8;
  localparam int WS_W       = 4;
  localparam int RM_W       = 3;
  localparam int NFLAG      = 8;
  localparam int LANES      = 4;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_EADDR = 8'h04;
  localparam logic [7:0] OFS_BCFG0 = 8'h08;
  localparam logic [7:0] OFS_BCFG1 = 8'h0C;
  localparam logic [7:0] OFS_PRM0  = 8'h10;
  localparam logic [7:0] OFS_PRM1  = 8'h14;
  localparam logic [7:0] OFS_PRI0  = 8'h18;
  localparam logic [7:0] OFS_PRI1  = 8'h1C;
  localparam logic [7:0] OFS_IFG   = 8'h20;
  localparam logic [7:0] OFS_IE    = 8'h24;
  localparam logic [7:0] OFS_MIFG  = 8'h28;
  localparam logic [7:0] OFS_ICLR  = 8'h2C;
  localparam logic [7:0] OFS_WPCTL = 8'h30;
  localparam logic [7:0] OFS_PADDR = 8'h34;
  localparam logic [7:0] OFS_PDATA = 8'h38;
  localparam logic [7:0] OFS_MAP   = 8'h3C;
  // control bits
  localparam int CTL_SERASE = 0;
  localparam int CTL_MERASE = 1;
  localparam int CTL_INFO   = 2;
  localparam int CFG_RM_LSB = 4;
  localparam int WP_EN      = 0;
  localparam int WP_COLL    = 1;
  localparam int MAP_OK     = 31;
  // interrupt flag positions
  localparam int F_FAULT = 0;
  localparam int F_BENCH = 1;
  localparam int F_ERASE = 2;
  localparam int F_BURST = 3;
  localparam int F_WORD  = 4;
  localparam int F_AFTER = 5;
  localparam int F_BEFOR = 6;
  localparam int F_CMP   = 7;
  // read modes
  typedef enum logic [2:0] {
    RM_NORMAL        = 3'h0,
    RM_LOW_MARGIN    = 3'h1,
    RM_HIGH_MARGIN   = 3'h2,
    RM_PROG_VERIFY   = 3'h3,
    RM_ERASE_VERIFY  = 3'h4,
    RM_LEAK_CHECK    = 3'h5,
    RM_LOW_MARGIN_B  = 3'h6,
    RM_HIGH_MARGIN_B = 3'h7
  } fesp_rmode_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ERASE = 4'h2,
    ST_MASS  = 4'h4,
    ST_PROG  = 4'h8
  } fesp_st_t;
  // request to the flash array
  typedef struct packed {
    logic              erase;
    logic              prog;
    logic              wide;
    logic              info;
    logic              bank;
    logic [SECT_W-1:0] sector;
    logic [31:0]       paddr;
    logic [127:0]      pdata;
  } fesp_cmd_t;
  // event pulses from the datapath outside
  typedef struct packed {
    logic fault;
    logic bench;
    logic burst_done;
    logic after_fail;
    logic before_fail;
    logic cmp_done;
  } fesp_evt_t;
  typedef struct packed {
    fesp_st_t                     st;
    logic                         wait_done;
    logic [1:0][WS_W-1:0]         wait_st;
    logic [1:0][RM_W-1:0]         rmode;
    logic [1:0][NSECT-1:0]        prot_main;
    logic [1:0][INFO_NSECT-1:0]   prot_info;
    logic [NFLAG-1:0]             ifg;
    logic [NFLAG-1:0]             ie;
    logic                         wp_en;
    logic                         wp_coll;
    logic [LANES-1:0]             lane_ok;
    logic [31:0]                  eaddr;
    logic                         einfo;
    logic [SECT_W+1:0]            scan;
    logic [31:0]                  maddr;
    logic [31:0]                  rdata;
    logic                         irq;
    logic [1:0]                   bank_busy;
    fesp_cmd_t                    cmd;
  } fesp_state_t;
endpackage

/* File: fesp_ctl.sv */
// flash erase, protection, read setup and interrupt status controller
`timescale 1ns/100ps
// Functional notes
// - erase granularity is one whole 4KB sector
// - unaligned erase address erases containing sector
// - mass erase skips protected sectors
// - mass erase self-runs, sets erase flag
// - masked status is raw AND enables
// - eight separate raw status flags
// - per-bank readable eight-way read mode
// - per-bank readable wait-state count
// - one protect bit per sector, space, bank
// - info space has sectors zero, one only
// - no info memory: info operations ignored
// - word-write status zero when disabled
// - main address maps to bank, sector
// - immediate programs now; collated waits 128 bits
// - only enabled sources drive interrupt
// - clearing flags removes their request
// - wait-state uses low four bits only
module fesp_ctl
  import fesp_pkg::*;
#(
  parameter bit HAS_INFO = 1'b1,
  parameter int MAIN_SECT = NSECT
)(
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  input  wire logic              fl_done_i,
  input  fesp_evt_t              evt_i,
  output fesp_cmd_t              fl_cmd_o,
  output logic [1:0]             bank_busy_o,
  output logic [1:0][WS_W-1:0]   wait_st_o,
  output logic [1:0][RM_W-1:0]   read_mode_o,
  output logic                   irq_o
);

  localparam int BANK_BIT = SECT_LSB + SECT_W;

  fesp_state_t s_ff;
  fesp_state_t nxt_s;

  // protection lookup shared by erase, mass erase and program paths
  function automatic logic is_prot(input fesp_state_t s, input logic info,
                                   input logic bank, input logic [SECT_W-1:0] sec);
    logic r;
    r = 1'b0;
    if (info)
    begin
      r = (sec >= SECT_W'(INFO_NSECT)) ? 1'b1 : s.prot_info[bank][sec[0]];
    end
    else
    begin
      r = s.prot_main[bank][sec];
    end
    return r;
  endfunction

  // sector exists and may be touched at all
  function automatic logic exists(input logic info, input logic [SECT_W-1:0] sec);
    logic r;
    r = 1'b0;
    if (info)
    begin
      r = HAS_INFO && (sec < SECT_W'(INFO_NSECT));
    end
    else
    begin
      r = ({1'b0, sec} < (SECT_W+1)'(MAIN_SECT));
    end
    return r;
  endfunction

  // main-space address to {valid, bank, sector}
  function automatic logic [31:0] map_addr(input logic [31:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[SECT_W-1:0] = a[SECT_LSB +: SECT_W];
    r[SECT_W] = a[BANK_BIT];
    r[MAP_OK] = (a[31:BANK_BIT+1] == '0) && exists(1'b0, a[SECT_LSB +: SECT_W]);
    return r;
  endfunction

  always_comb
  begin
    logic [NFLAG-1:0] set_f;
    logic [NFLAG-1:0] clr_f;
    logic             wr;
    logic             idle;
    logic             ebank;
    logic             pbank;
    logic             pinfo;
    logic [SECT_W-1:0] esec;
    logic [SECT_W-1:0] psec;
    logic             s_info;
    logic             s_bank;
    logic [SECT_W-1:0] s_sec;
    logic             s_last;
    logic [1:0]       lane;
    set_f  = '0;
    clr_f  = '0;
    nxt_s  = s_ff;
    wr     = reg_wr_i;
    idle   = (s_ff.st == ST_IDLE);
    ebank  = s_ff.eaddr[BANK_BIT];
    esec   = s_ff.eaddr[SECT_LSB +: SECT_W];
    pbank  = s_ff.cmd.paddr[BANK_BIT];
    psec   = s_ff.cmd.paddr[SECT_LSB +: SECT_W];
    pinfo  = s_ff.einfo;
    {s_info, s_bank, s_sec} = s_ff.scan;
    s_last = (s_ff.scan == '1);
    lane   = s_ff.cmd.paddr[3:2];
    nxt_s.cmd.erase = 1'b0;
    nxt_s.cmd.prog  = 1'b0;

    case (s_ff.st)
      ST_IDLE:
      begin
        nxt_s.bank_busy = 2'b00;
      end
      ST_ERASE:
      begin
        if (fl_done_i)
        begin
          set_f[F_ERASE] = 1'b1;
          nxt_s.st = ST_IDLE;
        end
      end
      ST_MASS:
      begin
        // one sector at a time, no bus help needed until the flag
        if (s_ff.wait_done)
        begin
          if (fl_done_i)
          begin
            nxt_s.wait_done = 1'b0;
            nxt_s.scan = s_ff.scan + 1'b1;
            if (s_last)
            begin
              set_f[F_ERASE] = 1'b1;
              nxt_s.st = ST_IDLE;
            end
          end
        end
        else if (exists(s_info, s_sec) && !is_prot(s_ff, s_info, s_bank, s_sec))
        begin
          nxt_s.cmd.erase  = 1'b1;
          nxt_s.cmd.info   = s_info;
          nxt_s.cmd.bank   = s_bank;
          nxt_s.cmd.sector = s_sec;
          nxt_s.bank_busy  = s_bank ? 2'b10 : 2'b01;
          nxt_s.wait_done  = 1'b1;
        end
        else
        begin
          nxt_s.scan = s_ff.scan + 1'b1;
          if (s_last)
          begin
            set_f[F_ERASE] = 1'b1;
            nxt_s.st = ST_IDLE;
          end
        end
      end
      ST_PROG:
      begin
        if (fl_done_i)
        begin
          set_f[F_WORD] = 1'b1;
          nxt_s.st = ST_IDLE;
        end
      end
      default:
      begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    // register writes; commands are only taken while idle
    if (wr)
    begin
      case (reg_addr_i)
        OFS_CTRL:
        begin
          if (idle && reg_wdata_i[CTL_MERASE])
          begin
            nxt_s.st        = ST_MASS;
            nxt_s.scan      = '0;
            nxt_s.wait_done = 1'b0;
          end
          else if (idle && reg_wdata_i[CTL_SERASE])
          begin
            if (!exists(reg_wdata_i[CTL_INFO], esec))
            begin
              // absent sector or info space: silently dropped
              nxt_s.st = ST_IDLE;
            end
            else if (is_prot(s_ff, reg_wdata_i[CTL_INFO], ebank, esec))
            begin
              set_f[F_FAULT] = 1'b1;
            end
            else
            begin
              nxt_s.cmd.erase  = 1'b1;
              nxt_s.cmd.info   = reg_wdata_i[CTL_INFO];
              nxt_s.cmd.bank   = ebank;
              nxt_s.cmd.sector = esec;
              nxt_s.bank_busy  = ebank ? 2'b10 : 2'b01;
              nxt_s.st         = ST_ERASE;
            end
          end
          nxt_s.einfo = reg_wdata_i[CTL_INFO];
        end
        OFS_EADDR: nxt_s.eaddr = reg_wdata_i;
        OFS_BCFG0:
        begin
          nxt_s.wait_st[0] = reg_wdata_i[WS_W-1:0];
          nxt_s.rmode[0]   = reg_wdata_i[CFG_RM_LSB +: RM_W];
        end
        OFS_BCFG1:
        begin
          nxt_s.wait_st[1] = reg_wdata_i[WS_W-1:0];
          nxt_s.rmode[1]   = reg_wdata_i[CFG_RM_LSB +: RM_W];
        end
        OFS_PRM0: nxt_s.prot_main[0] = reg_wdata_i[NSECT-1:0];
        OFS_PRM1: nxt_s.prot_main[1] = reg_wdata_i[NSECT-1:0];
        OFS_PRI0:
        begin
          if (HAS_INFO)
          begin
            nxt_s.prot_info[0] = reg_wdata_i[INFO_NSECT-1:0];
          end
        end
        OFS_PRI1:
        begin
          if (HAS_INFO)
          begin
            nxt_s.prot_info[1] = reg_wdata_i[INFO_NSECT-1:0];
          end
        end
        OFS_IE:    nxt_s.ie = reg_wdata_i[NFLAG-1:0];
        OFS_ICLR:  clr_f = reg_wdata_i[NFLAG-1:0];
        OFS_WPCTL:
        begin
          nxt_s.wp_en   = reg_wdata_i[WP_EN];
          nxt_s.wp_coll = reg_wdata_i[WP_COLL];
          nxt_s.lane_ok = '0;
        end
        OFS_PADDR: nxt_s.cmd.paddr = reg_wdata_i;
        OFS_PDATA:
        begin
          if (idle && s_ff.wp_en)
          begin
            if (!exists(pinfo, psec))
            begin
              nxt_s.lane_ok = s_ff.lane_ok;
            end
            else if (is_prot(s_ff, pinfo, pbank, psec))
            begin
              set_f[F_FAULT] = 1'b1;
            end
            else if (!s_ff.wp_coll)
            begin
              // immediate: one word goes out at once
              nxt_s.cmd.pdata = {96'h0, reg_wdata_i};
              nxt_s.cmd.wide  = 1'b0;
              nxt_s.cmd.info  = pinfo;
              nxt_s.cmd.prog  = 1'b1;
              nxt_s.bank_busy = pbank ? 2'b10 : 2'b01;
              nxt_s.st        = ST_PROG;
            end
            else
            begin
              // collated: lane by address, fire once all four lanes are written
              nxt_s.cmd.pdata[lane*32 +: 32] = reg_wdata_i;
              nxt_s.lane_ok[lane] = 1'b1;
              if ((s_ff.lane_ok | (LANES'(1) << lane)) == '1)
              begin
                nxt_s.lane_ok   = '0;
                nxt_s.cmd.wide  = 1'b1;
                nxt_s.cmd.info  = pinfo;
                nxt_s.cmd.prog  = 1'b1;
                nxt_s.bank_busy = pbank ? 2'b10 : 2'b01;
                nxt_s.st        = ST_PROG;
              end
            end
          end
        end
        OFS_MAP:   nxt_s.maddr = reg_wdata_i;
        default:   nxt_s.maddr = s_ff.maddr;
      endcase
    end

    set_f[F_FAULT] = set_f[F_FAULT] | evt_i.fault;
    set_f[F_BENCH] = evt_i.bench;
    set_f[F_BURST] = evt_i.burst_done;
    set_f[F_AFTER] = evt_i.after_fail;
    set_f[F_BEFOR] = evt_i.before_fail;
    set_f[F_CMP]   = evt_i.cmp_done;
    // a new event in the clearing cycle survives
    nxt_s.ifg = (s_ff.ifg & ~clr_f) | set_f;
    nxt_s.irq = |(nxt_s.ifg & nxt_s.ie);

    // read data stands in the cycle after the strobe only
    nxt_s.rdata = 32'h0000_0000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        OFS_CTRL:  nxt_s.rdata = {30'h0, s_ff.einfo, !idle};
        OFS_EADDR: nxt_s.rdata = s_ff.eaddr;
        OFS_BCFG0: nxt_s.rdata = 32'({s_ff.rmode[0], s_ff.wait_st[0]});
        OFS_BCFG1: nxt_s.rdata = 32'({s_ff.rmode[1], s_ff.wait_st[1]});
        OFS_PRM0:  nxt_s.rdata = s_ff.prot_main[0];
        OFS_PRM1:  nxt_s.rdata = s_ff.prot_main[1];
        OFS_PRI0:  nxt_s.rdata = 32'(s_ff.prot_info[0]);
        OFS_PRI1:  nxt_s.rdata = 32'(s_ff.prot_info[1]);
        OFS_IFG:   nxt_s.rdata = 32'(s_ff.ifg);
        OFS_IE:    nxt_s.rdata = 32'(s_ff.ie);
        OFS_MIFG:  nxt_s.rdata = 32'(s_ff.ifg & s_ff.ie);
        OFS_WPCTL: nxt_s.rdata = {30'h0, s_ff.wp_en & s_ff.wp_coll, s_ff.wp_en};
        OFS_PADDR: nxt_s.rdata = s_ff.cmd.paddr;
        OFS_MAP:   nxt_s.rdata = map_addr(s_ff.maddr);
        default:   nxt_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      s_ff    <= '0;
      s_ff.st <= ST_IDLE;
      // all sectors start protected so a stray erase cannot harm code
      s_ff.prot_main <= '1;
      s_ff.prot_info <= '1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata_o = s_ff.rdata;
  assign fl_cmd_o    = s_ff.cmd;
  assign bank_busy_o = s_ff.bank_busy;
  assign wait_st_o   = s_ff.wait_st;
  assign read_mode_o = s_ff.rmode;
  assign irq_o       = s_ff.irq;

endmodule

/* File: fesp_ctl_chk.sv */
// port-level assertion checker for the flash controller
`timescale 1ns/100ps
module fesp_ctl_chk
  import fesp_pkg::*;
(
  input wire logic                 core_clk_i,
  input wire logic                 srst_i,
  input wire logic [ADDR_W-1:0]    reg_addr_i,
  input wire logic [31:0]          reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire logic [31:0]          reg_rdata_o,
  input fesp_cmd_t                 fl_cmd_o,
  input wire logic [1:0]           bank_busy_o,
  input wire logic [1:0][WS_W-1:0] wait_st_o,
  input wire logic [1:0][RM_W-1:0] read_mode_o,
  input wire logic                 irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not zero outside read cycle");
  a_wait_low: assert property (reg_wr_i && reg_addr_i == OFS_BCFG0 |->
    ##2 wait_st_o[0] == $past(reg_wdata_i[3:0], 2)) else $error("wait state mismatch");
  a_mode_upper: assert property (reg_wr_i && reg_addr_i == OFS_BCFG1 |->
    ##2 read_mode_o[1] == $past(reg_wdata_i[6:4], 2)) else $error("read mode mismatch");
  a_erase_busy: assert property (fl_cmd_o.erase |-> bank_busy_o[fl_cmd_o.bank])
    else $error("erase without busy bank");
  a_erase_pulse: assert property (fl_cmd_o.erase |=> !fl_cmd_o.erase)
    else $error("erase command longer than one cycle");
  a_info_sector: assert property (fl_cmd_o.erase && fl_cmd_o.info |-> fl_cmd_o.sector < 2)
    else $error("info erase beyond sector one");
  a_single_op: assert property (!(fl_cmd_o.erase && fl_cmd_o.prog))
    else $error("erase and program together");
  a_irq_masked: assert property (reg_wr_i && reg_addr_i == OFS_IE &&
    reg_wdata_i[7:0] == 8'h00 |-> ##2 !irq_o)
    else $error("interrupt with all sources disabled");
endmodule
bind fesp_ctl fesp_ctl_chk u_chk(.core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .fl_cmd_o, .bank_busy_o, .wait_st_o, .read_mode_o, .irq_o);

/* File: fesp_flash_mdl.sv */
// flash array stand-in: answers each erase or program after a slow or a quick delay
`timescale 1ns/100ps
module fesp_flash_mdl
  import fesp_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  fesp_cmd_t cmd_i,
  output logic      done_o
);
  int cnt = 0;
  bit slow = 1'b1;
  // alternating delays so busy status is seen both briefly and at length
  always @(posedge core_clk_i)
  begin
    done_o <= 1'b0;
    if (srst_i)
    begin
      cnt <= 0;
      slow <= 1'b1;
    end
    else if (cmd_i.erase || cmd_i.prog)
    begin
      cnt <= slow ? 8 : 1;
      slow <= ~slow;
    end
    else if (cnt == 1)
    begin
      done_o <= 1'b1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

/* File: tb_top.sv */
// testbench: register-bus scenarios checked against expected values computed in the test
`timescale 1ns/100ps
module tb_top;
  import fesp_pkg::*;
  logic                 core_clk_i = 1'b0;
  logic                 srst_i = 1'b1;
  logic [ADDR_W-1:0]    reg_addr_i = '0;
  logic [31:0]          reg_wdata_i = '0;
  logic                 reg_wr_i = 1'b0;
  logic                 reg_rd_i = 1'b0;
  logic [31:0]          reg_rdata_o;
  logic                 fl_done_i;
  fesp_evt_t            evt_i = '0;
  fesp_cmd_t            fl_cmd_o;
  logic [1:0]           bank_busy_o;
  logic [1:0][WS_W-1:0] wait_st_o;
  logic [1:0][RM_W-1:0] read_mode_o;
  logic                 irq_o;
  int                   miscompares = 0;
  int                   n_checks = 0;
  int                   ers_q[$];
  int                   n_prog = 0;
  logic                 wide_seen;
  logic [127:0]         pdata_seen;
  always #10 core_clk_i = ~core_clk_i;
  fesp_ctl u_dut(.core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .fl_done_i, .evt_i, .fl_cmd_o, .bank_busy_o, .wait_st_o, .read_mode_o, .irq_o);
  fesp_flash_mdl u_fl(.core_clk_i, .srst_i, .cmd_i(fl_cmd_o), .done_o(fl_done_i));
  always @(posedge core_clk_i)
  begin
    if (fl_cmd_o.erase === 1'b1)
      ers_q.push_back(int'({fl_cmd_o.info, fl_cmd_o.bank, fl_cmd_o.sector}));
    if (fl_cmd_o.prog === 1'b1)
    begin
      n_prog++;
      wide_seen = fl_cmd_o.wide;
      pdata_seen = fl_cmd_o.pdata;
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] exp, string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, exp, d);
  endtask
  // requester waits for completion before touching the bank again
  task automatic wait_flag(int b);
    logic [31:0] d;
    for (int i = 0; i < 500; i++)
    begin
      rd(OFS_IFG, d);
      if (d[b] === 1'b1)
        return;
    end
    chk("flag wait", 32'h1 << b, d);
    summarize();
  endtask
  initial
  begin
    logic [31:0] d;
    logic [127:0] exp_set, seen;
    logic [1:0][31:0] pm;
    logic [1:0][1:0] pi;
    int ws, acc;
    int fpos[6] = '{0, 1, 3, 5, 6, 7};
    void'($urandom(32'h76b8));
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rdchk(OFS_PRM0, 32'hFFFFFFFF, "main protect");
    rdchk(OFS_PRI1, 32'h3, "info protect");
    wr(OFS_PRI0, 32'hFFFFFFFC);
    rdchk(OFS_PRI0, 32'h0, "info protect");
    $display("test reset done");
    for (int m = 0; m < 8; m++)
    begin
      ws = $urandom;
      wr(m[0] ? OFS_BCFG1 : OFS_BCFG0, {ws[31:7], m[2:0], ws[3:0]});
      rdchk(m[0] ? OFS_BCFG1 : OFS_BCFG0, {25'h0, m[2:0], ws[3:0]}, "bank cfg");
      chk("wait out", 32'(ws[3:0]), 32'(wait_st_o[m[0]]));
      chk("mode out", 32'(m[2:0]), 32'(read_mode_o[m[0]]));
    end
    $display("test bank config done");
    wr(OFS_PRM1, ~32'h20);
    wr(OFS_EADDR, 32'h25000 | ($urandom & 32'hFFF));
    ers_q.delete();
    wr(OFS_CTRL, 32'h1);
    rdchk(OFS_CTRL, 32'h1, "busy");
    chk("bank busy", 32'h2, 32'(bank_busy_o));
    wait_flag(F_ERASE);
    chk("erase count", 1, ers_q.size());
    chk("erase target", 32'h25, ers_q[0]);
    rdchk(OFS_IFG, 32'h4, "sticky");
    chk("bank busy", 0, 32'(bank_busy_o));
    wr(OFS_ICLR, 32'hFF);
    wr(OFS_EADDR, 32'h26000);
    wr(OFS_CTRL, 32'h1);
    repeat (12) @(posedge core_clk_i);
    rdchk(OFS_IFG, 32'h1, "fault");
    chk("erase count", 1, ers_q.size());
    $display("test sector erase done");
    pm[0] = ~32'h81;
    pm[1] = ~32'h20;
    pi = 4'b1110;
    wr(OFS_ICLR, 32'hFF);
    wr(OFS_PRM0, pm[0]);
    wr(OFS_PRI0, 32'(pi[0]));
    wr(OFS_PRI1, 32'(pi[1]));
    ers_q.delete();
    wr(OFS_CTRL, 32'h2);
    wait_flag(F_ERASE);
    exp_set = '0;
    seen = '0;
    for (int i = 0; i < 128; i++)
      exp_set[i] = i[6] ? (i[4:0] < 2 && !pi[i[5]][i[0]]) : !pm[i[5]][i[4:0]];
    foreach (ers_q[i])
      seen[ers_q[i][6:0]] = 1'b1;
    chk("mass count", $countones(exp_set), ers_q.size());
    for (int i = 0; i < 4; i++)
      chk("mass set", exp_set[i*32 +: 32], seen[i*32 +: 32]);
    $display("test mass erase done");
    wr(OFS_ICLR, 32'hFF);
    wr(OFS_IE, 32'h0);
    acc = 0;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge core_clk_i);
      evt_i <= fesp_evt_t'(6'h20 >> k);
      @(posedge core_clk_i);
      evt_i <= '0;
      acc |= 1 << fpos[k];
      rdchk(OFS_IFG, acc, "raw flags");
    end
    chk("irq", 0, 32'(irq_o));
    ws = $urandom & 32'hFF;
    wr(OFS_IE, ws);
    rdchk(OFS_MIFG, acc & ws, "masked");
    chk("irq", 32'((acc & ws) != 0), 32'(irq_o));
    wr(OFS_ICLR, 32'h0F);
    rdchk(OFS_IFG, acc & 32'hF0, "cleared");
    wr(OFS_IE, 32'hFF);
    rdchk(OFS_MIFG, acc & 32'hF0, "masked");
    chk("irq", 1, 32'(irq_o));
    wr(OFS_ICLR, 32'hFF);
    rdchk(OFS_MIFG, 0, "masked cleared");
    chk("irq", 0, 32'(irq_o));
    wr(OFS_IE, 32'h0);
    $display("test interrupts done");
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_WPCTL, m);
      rdchk(OFS_WPCTL, (m == 3) ? 3 : (m & 1), "word status");
    end
    acc = n_prog;
    for (int l = 0; l < 4; l++)
    begin
      d = $urandom;
      exp_set[l*32 +: 32] = d;
      wr(OFS_PADDR, 32'h25000 + l * 4);
      wr(OFS_PDATA, d);
      repeat (2) @(posedge core_clk_i);
      chk("collated", acc + (l == 3), n_prog);
    end
    chk("wide", 1, 32'(wide_seen));
    for (int l = 0; l < 4; l++)
      chk("collated data", exp_set[l*32 +: 32], pdata_seen[l*32 +: 32]);
    wait_flag(F_WORD);
    wr(OFS_ICLR, 32'h10);
    wr(OFS_WPCTL, 32'h1);
    wr(OFS_PADDR, 32'h25010);
    d = $urandom;
    wr(OFS_PDATA, d);
    repeat (2) @(posedge core_clk_i);
    chk("immediate", acc + 2, n_prog);
    chk("wide", 0, 32'(wide_seen));
    chk("immediate data", d, pdata_seen[31:0]);
    wait_flag(F_WORD);
    $display("test word program done");
    wr(OFS_MAP, 32'h29123);
    rdchk(OFS_MAP, 32'h80000029, "map");
    wr(OFS_MAP, 32'h40000);
    rd(OFS_MAP, d);
    chk("map ok", 0, 32'(d[MAP_OK]));
    $display("test map done");
    summarize();
  end
endmodule
